// file: hdl/dagen_pkg.sv
// Constants and types shared by the data address generator
package dagen_pkg;
   // Register byte offsets
   localparam logic [11:0] OFS_PAGE = 12'h000;
   localparam logic [11:0] OFS_LIMIT = 12'h004;
   localparam logic [11:0] OFS_SP = 12'h008;
   localparam logic [11:0] OFS_MODCTL = 12'h00c;
   localparam logic [11:0] OFS_XSTART = 12'h010;
   localparam logic [11:0] OFS_XEND = 12'h014;
   localparam logic [11:0] OFS_YSTART = 12'h018;
   localparam logic [11:0] OFS_YEND = 12'h01c;
   localparam logic [11:0] OFS_BRMOD = 12'h020;
   localparam logic [11:0] OFS_PROT = 12'h024;
   localparam logic [11:0] OFS_STATUS = 12'h028;
   // Mode control fields
   localparam int MC_XEN = 0;
   localparam int MC_YEN = 1;
   localparam int MC_BREN = 2;
   localparam int MC_XREG = 4;
   localparam int MC_YREG = 8;
   localparam int MC_BRREG = 12;
   // Protection enables and sticky status bits
   localparam int PROT_BOOT = 0;
   localparam int PROT_SEC = 1;
   localparam int ST_OVF = 0;
   localparam int ST_UNF = 1;
   localparam int ST_VIOL = 2;
   // Address constants and reset values
   localparam logic [15:0] SFR_TOP = 16'h0800;
   localparam logic [15:0] WORD_STEP = 16'h0002;
   localparam logic [15:0] DWORD_STEP = 16'h0004;
   localparam logic [3:0] STACK_REG = 4'hf;
   localparam logic [15:0] BOOT_LO = 16'h0c00;
   localparam logic [15:0] BOOT_HI = 16'h0dff;
   localparam logic [15:0] SEC_LO = 16'h0e00;
   localparam logic [15:0] SEC_HI = 16'h0fff;
   localparam logic [15:0] SP_RST = 16'h0800;
   localparam logic [15:0] LIMIT_RST = 16'h0000;
   localparam logic [15:0] REG_RST = 16'h0000;
   typedef enum logic [4:0] {
      S_IDLE = 5'b00001, S_PUSH2 = 5'b00010, S_WIN = 5'b00100, S_RD1 = 5'b01000, S_RD2 = 5'b10000
   } state_t;
   typedef enum logic [2:0] {
      OP_MEM = 3'h0, OP_PUSH = 3'h1, OP_POP = 3'h2, OP_CALL = 3'h3, OP_EXC = 3'h4, OP_TBLRD = 3'h5, OP_TBLWT = 3'h6
   } op_t;
   typedef enum logic [2:0] {
      AM_IND = 3'h0, AM_POST = 3'h1, AM_PRE = 3'h2, AM_OFS = 3'h3, AM_DIR13 = 3'h4, AM_DIR16 = 3'h5
   } mode_t;
   typedef enum logic [1:0] {CODE_GEN = 2'h0, CODE_BOOT = 2'h1, CODE_SEC = 2'h2} code_t;
endpackage : dagen_pkg

// file: hdl/data_address_generation_stack_check.sv
// Data address generator with stack checks, program window and RAM protection
`timescale 1ns/1ps
`default_nettype none
module data_address_generation_stack_check (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ag_valid,
   output logic ag_ready,
   input wire logic [2:0] ag_op,
   input wire logic [2:0] ag_mode,
   input wire logic [3:0] ag_reg,
   input wire logic [15:0] ag_ptr,
   input wire logic [15:0] ag_mod,
   input wire logic [15:0] ag_lit,
   input wire logic ag_we,
   input wire logic ag_byte,
   input wire logic [23:0] ag_wdata,
   input wire logic [15:0] ag_old,
   input wire logic [22:0] ag_pc,
   input wire logic [7:0] status_low_byte,
   input wire logic [1:0] ag_code,
   input wire logic [7:0] ag_tblpage,
   input wire logic ag_dual,
   input wire logic [3:0] ag_yreg,
   input wire logic [15:0] ag_yptr,
   input wire logic [15:0] ag_ymod,
   output logic x_req,
   output logic x_we,
   output logic [1:0] x_be,
   output logic [15:0] x_addr,
   output logic [15:0] x_wdata,
   input wire logic [15:0] x_rdata,
   output logic y_req,
   output logic [15:0] y_addr,
   input wire logic [15:0] y_rdata,
   output logic p_req,
   output logic p_we,
   output logic [22:0] p_addr,
   output logic [23:0] p_wdata,
   input wire logic [23:0] p_rdata,
   output logic wb_valid,
   output logic [3:0] wb_reg,
   output logic [15:0] wb_value,
   output logic ywb_valid,
   output logic [3:0] ywb_reg,
   output logic [15:0] ywb_value,
   output logic rsp_valid,
   output logic [23:0] rsp_data,
   output logic [15:0] rsp_ydata,
   output logic stack_trap,
   output logic prot_violation,
   output logic [15:0] stack_pointer_register
);
   typedef struct packed {
      dagen_pkg::state_t st;
      logic [15:0] sp, lim, ctl, xs, xe, ys, ye;
      logic [14:0] xb;
      logic [7:0] page;
      logic [1:0] prot;
      logic [2:0] sticky;
      logic pready, pslverr;
      logic [31:0] prdata;
      logic rdy, xreq, xwe;
      logic [1:0] xbe;
      logic [15:0] xaddr, xwdata;
      logic yreq;
      logic [15:0] yaddr;
      logic preq, pwe;
      logic [22:0] paddr;
      logic [23:0] pwdata;
      logic wbv;
      logic [3:0] wbr;
      logic [15:0] wbval;
      logic ywbv;
      logic [3:0] ywbr;
      logic [15:0] ywbval;
      logic trap, viol, rspv;
      logic [23:0] rsp;
      logic [15:0] rspy;
      logic kwin, ktbl, kbyte, khi;
      logic [7:0] oldhi;
      logic [15:0] hiword;
   } regs_t;

   regs_t s_q;
   regs_t s_d;

   // Tests beyond either bound, so jumps past an edge wrap
   function automatic logic [15:0] wrap(input logic [15:0] ea, input logic [15:0] lo, input logic [15:0] hi);
      logic [15:0] len;
      len = hi - lo + 16'h0001;
      if (ea > hi) begin
         wrap = ea - len;
      end else if (ea < lo) begin
         wrap = ea + len;
      end else begin
         wrap = ea;
      end
   endfunction : wrap

   // Reverse-carry add of the pivot; words only, so bit 0 is clear
   function automatic logic [15:0] bradd(input logic [15:0] p, input logic [14:0] m);
      logic [14:0] rp;
      logic [14:0] rm;
      logic [14:0] rs;
      logic [14:0] r;
      for (int i = 0; i < 15; i++) begin
         rp[i] = p[15-i];
         rm[i] = m[14-i];
      end
      rs = rp + rm;
      for (int i = 0; i < 15; i++) begin
         r[i] = rs[14-i];
      end
      bradd = {r, 1'b0};
   endfunction : bradd

   function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
      in_rng = (a >= lo) && (a <= hi);
   endfunction : in_rng

   // Next state: registers, request engine and responses
   always_comb begin
      logic acc;
      logic [31:0] rd;
      logic hit;
      logic [15:0] ea, upd, yea, yupd, nsp;
      logic modify, br, stk, pushy, ovf, unf, viol;
      acc = psel & penable & ~s_q.pready;
      rd = '0;
      hit = 1'b1;
      ea = ag_ptr;
      upd = ag_ptr;
      yea = ag_yptr;
      yupd = ag_yptr;
      nsp = s_q.sp;
      modify = 1'b0;
      br = 1'b0;
      stk = 1'b0;
      pushy = 1'b0;
      ovf = 1'b0;
      unf = 1'b0;
      viol = 1'b0;
      s_d = s_q;
      s_d.pready = 1'b0;
      s_d.pslverr = 1'b0;
      s_d.xreq = 1'b0;
      s_d.yreq = 1'b0;
      s_d.preq = 1'b0;
      s_d.wbv = 1'b0;
      s_d.ywbv = 1'b0;
      s_d.trap = 1'b0;
      s_d.viol = 1'b0;
      s_d.rspv = 1'b0;

      // APB slave: one wait state, outputs from flops
      case (paddr)
         dagen_pkg::OFS_PAGE: rd = {24'h0, s_q.page};
         dagen_pkg::OFS_LIMIT: rd = {16'h0, s_q.lim};
         dagen_pkg::OFS_SP: rd = {16'h0, s_q.sp};
         dagen_pkg::OFS_MODCTL: rd = {16'h0, s_q.ctl};
         dagen_pkg::OFS_XSTART: rd = {16'h0, s_q.xs};
         dagen_pkg::OFS_XEND: rd = {16'h0, s_q.xe};
         dagen_pkg::OFS_YSTART: rd = {16'h0, s_q.ys};
         dagen_pkg::OFS_YEND: rd = {16'h0, s_q.ye};
         dagen_pkg::OFS_BRMOD: rd = {17'h0, s_q.xb};
         dagen_pkg::OFS_PROT: rd = {30'h0, s_q.prot};
         dagen_pkg::OFS_STATUS: rd = {29'h0, s_q.sticky};
         default: hit = 1'b0;
      endcase
      if (acc) begin
         s_d.pready = 1'b1;
         s_d.pslverr = ~hit;
         s_d.prdata = (hit && !pwrite) ? rd : 32'h0;
      end
      if (acc && pwrite) begin
         case (paddr)
            dagen_pkg::OFS_PAGE: s_d.page = pwdata[7:0];
            dagen_pkg::OFS_LIMIT: s_d.lim = {pwdata[15:1], 1'b0};
            dagen_pkg::OFS_SP: s_d.sp = {pwdata[15:1], 1'b0};
            dagen_pkg::OFS_MODCTL: s_d.ctl = pwdata[15:0];
            dagen_pkg::OFS_XSTART: s_d.xs = pwdata[15:0];
            dagen_pkg::OFS_XEND: s_d.xe = pwdata[15:0];
            dagen_pkg::OFS_YSTART: s_d.ys = pwdata[15:0];
            dagen_pkg::OFS_YEND: s_d.ye = pwdata[15:0];
            dagen_pkg::OFS_BRMOD: s_d.xb = pwdata[14:0];
            dagen_pkg::OFS_PROT: s_d.prot = pwdata[1:0];
            dagen_pkg::OFS_STATUS: s_d.sticky = s_q.sticky & ~pwdata[2:0];
            default: ;
         endcase
      end

      // X effective address; ordinary accesses use only this generator
      case (ag_mode)
         dagen_pkg::AM_POST: begin
            upd = ag_ptr + ag_mod;
            modify = 1'b1;
         end
         dagen_pkg::AM_PRE: begin
            ea = ag_ptr + ag_mod;
            upd = ea;
            modify = 1'b1;
         end
         dagen_pkg::AM_OFS: ea = ag_ptr + ag_mod;
         dagen_pkg::AM_DIR13: ea = {3'h0, ag_lit[12:0]};
         dagen_pkg::AM_DIR16: ea = ag_lit;
         default: ea = ag_ptr;
      endcase
      br = s_q.ctl[dagen_pkg::MC_BREN] && ag_we && !ag_byte && modify && !ag_mod[15]
         && ag_reg == s_q.ctl[dagen_pkg::MC_BRREG +: 4] && ag_reg != dagen_pkg::STACK_REG;
      if (br) begin
         // Bit reversal wins on writes; no circular wrap here
         upd = bradd(ag_ptr, s_q.xb);
         ea = (ag_mode == dagen_pkg::AM_POST) ? {ag_ptr[15:1], 1'b0} : upd;
      end else if (s_q.ctl[dagen_pkg::MC_XEN] && ag_reg == s_q.ctl[dagen_pkg::MC_XREG +: 4]
                   && ag_mode != dagen_pkg::AM_DIR13 && ag_mode != dagen_pkg::AM_DIR16) begin
         if (ag_mode != dagen_pkg::AM_POST) begin
            ea = wrap(ea, s_q.xs, s_q.xe);
         end
         upd = wrap(upd, s_q.xs, s_q.xe);
      end

      // Y generator: dual fetch only, post-modified
      yupd = ag_yptr + ag_ymod;
      if (s_q.ctl[dagen_pkg::MC_YEN] && ag_yreg == s_q.ctl[dagen_pkg::MC_YREG +: 4]) begin
         yupd = wrap(yupd, s_q.ys, s_q.ye);
      end

      // Stack ops use the held stack pointer instead of the pointer port
      case (ag_op)
         dagen_pkg::OP_PUSH, dagen_pkg::OP_CALL, dagen_pkg::OP_EXC: begin
            ea = s_q.sp;
            nsp = s_q.sp + dagen_pkg::WORD_STEP;
            stk = 1'b1;
            pushy = 1'b1;
         end
         dagen_pkg::OP_POP: begin
            ea = s_q.sp - dagen_pkg::WORD_STEP;
            nsp = ea;
            stk = 1'b1;
         end
         default: begin
            stk = ag_reg == dagen_pkg::STACK_REG && ag_mode != dagen_pkg::AM_DIR13
               && ag_mode != dagen_pkg::AM_DIR16;
            pushy = stk && ag_we;
         end
      endcase
      if (s_q.st == dagen_pkg::S_PUSH2) begin
         ea = s_q.sp + dagen_pkg::WORD_STEP;
         stk = 1'b1;
         pushy = 1'b1;
      end
      // Equal to the limit passes; the next push lands above it and traps
      ovf = stk && pushy && (ea > s_q.lim);
      unf = stk && (ea < dagen_pkg::SFR_TOP);
      viol = ag_op == dagen_pkg::OP_MEM && !ag_dual
         && ((s_q.prot[dagen_pkg::PROT_BOOT] && in_rng(ea, dagen_pkg::BOOT_LO, dagen_pkg::BOOT_HI)
              && ag_code != dagen_pkg::CODE_BOOT)
          || (s_q.prot[dagen_pkg::PROT_SEC] && in_rng(ea, dagen_pkg::SEC_LO, dagen_pkg::SEC_HI)
              && ag_code != dagen_pkg::CODE_SEC));

      // Request engine
      case (s_q.st)
         dagen_pkg::S_IDLE: begin
            if (ag_valid && s_q.rdy) begin
               s_d.trap = ovf | unf;
               s_d.kwin = 1'b0;
               s_d.ktbl = 1'b0;
               s_d.kbyte = ag_byte;
               s_d.khi = ea[0];
               s_d.oldhi = ag_old[15:8];
               s_d.xaddr = ea;
               s_d.xwe = ag_we;
               s_d.xbe = 2'b11;
               s_d.xwdata = ag_wdata[15:0];
               case (ag_op)
                  dagen_pkg::OP_MEM: begin
                     if (viol) begin
                        // Rejected access: no memory cycle, reads get zero
                        s_d.viol = 1'b1;
                        s_d.rspv = ~ag_we;
                        s_d.rsp = 24'h0;
                        s_d.rspy = 16'h0;
                     end else if (!ag_we && ea[15] && !ag_dual) begin
                        s_d.preq = 1'b1;
                        s_d.pwe = 1'b0;
                        s_d.paddr = {s_q.page, ea[14:0]};
                        s_d.kwin = 1'b1;
                        s_d.st = dagen_pkg::S_WIN;
                     end else begin
                        s_d.xreq = 1'b1;
                        if (ag_byte && ag_we) begin
                           s_d.xbe = ea[0] ? 2'b10 : 2'b01;
                           s_d.xwdata = {ag_wdata[7:0], ag_wdata[7:0]};
                        end
                        if (ag_dual) begin
                           s_d.yreq = 1'b1;
                           s_d.yaddr = yea;
                           s_d.ywbv = 1'b1;
                           s_d.ywbr = ag_yreg;
                           s_d.ywbval = yupd;
                        end
                        s_d.st = ag_we ? dagen_pkg::S_IDLE : dagen_pkg::S_RD1;
                     end
                     if (!viol && modify) begin
                        // Offset form wraps the address but leaves the pointer alone
                        s_d.wbv = 1'b1;
                        s_d.wbr = ag_reg;
                        s_d.wbval = upd;
                        if (ag_reg == dagen_pkg::STACK_REG) begin
                           s_d.sp = {upd[15:1], 1'b0};
                        end
                     end
                  end
                  dagen_pkg::OP_TBLRD, dagen_pkg::OP_TBLWT: begin
                     s_d.preq = 1'b1;
                     s_d.pwe = ag_op == dagen_pkg::OP_TBLWT;
                     s_d.paddr = {ag_tblpage[6:0], ea};
                     s_d.pwdata = ag_wdata;
                     s_d.ktbl = 1'b1;
                     s_d.st = (ag_op == dagen_pkg::OP_TBLWT) ? dagen_pkg::S_IDLE : dagen_pkg::S_RD1;
                     if (modify) begin
                        s_d.wbv = 1'b1;
                        s_d.wbr = ag_reg;
                        s_d.wbval = upd;
                     end
                  end
                  default: begin
                     s_d.xreq = 1'b1;
                     s_d.xwe = pushy;
                     if (ag_op == dagen_pkg::OP_CALL || ag_op == dagen_pkg::OP_EXC) begin
                        s_d.xwdata = ag_pc[15:0];
                        s_d.hiword = {(ag_op == dagen_pkg::OP_EXC) ? status_low_byte : 8'h00,
                                      1'b0, ag_pc[22:16]};
                        s_d.st = dagen_pkg::S_PUSH2;
                     end else begin
                        s_d.sp = nsp;
                        s_d.wbv = 1'b1;
                        s_d.wbr = dagen_pkg::STACK_REG;
                        s_d.wbval = nsp;
                        s_d.st = pushy ? dagen_pkg::S_IDLE : dagen_pkg::S_RD1;
                     end
                  end
               endcase
            end
         end
         dagen_pkg::S_PUSH2: begin
            // Second word of a call or exception push carries the counter top
            s_d.trap = ovf | unf;
            s_d.xreq = 1'b1;
            s_d.xwe = 1'b1;
            s_d.xbe = 2'b11;
            s_d.xaddr = ea;
            s_d.xwdata = s_q.hiword;
            s_d.sp = s_q.sp + dagen_pkg::DWORD_STEP;
            s_d.wbv = 1'b1;
            s_d.wbr = dagen_pkg::STACK_REG;
            s_d.wbval = s_q.sp + dagen_pkg::DWORD_STEP;
            s_d.st = dagen_pkg::S_IDLE;
         end
         dagen_pkg::S_WIN: begin
            // Program memory is held one more cycle for the window fetch
            s_d.preq = 1'b1;
            s_d.st = dagen_pkg::S_RD1;
         end
         dagen_pkg::S_RD1: s_d.st = dagen_pkg::S_RD2;
         dagen_pkg::S_RD2: begin
            s_d.rspv = 1'b1;
            s_d.rspy = y_rdata;
            if (s_q.kwin) begin
               s_d.rsp = {8'h00, p_rdata[15:0]};
            end else if (s_q.ktbl) begin
               s_d.rsp = p_rdata;
            end else if (s_q.kbyte) begin
               s_d.rsp = {8'h00, s_q.oldhi, s_q.khi ? x_rdata[15:8] : x_rdata[7:0]};
            end else begin
               s_d.rsp = {8'h00, x_rdata};
            end
            s_d.st = dagen_pkg::S_IDLE;
         end
         default: s_d.st = dagen_pkg::S_IDLE;
      endcase

      // Set after the clear, so a same-cycle event wins
      s_d.sticky[dagen_pkg::ST_OVF] = s_d.sticky[dagen_pkg::ST_OVF] | (s_d.trap & ovf);
      s_d.sticky[dagen_pkg::ST_UNF] = s_d.sticky[dagen_pkg::ST_UNF] | (s_d.trap & unf);
      s_d.sticky[dagen_pkg::ST_VIOL] = s_d.sticky[dagen_pkg::ST_VIOL] | s_d.viol;
      s_d.rdy = s_d.st == dagen_pkg::S_IDLE;
   end

   // Limit resets to LIMIT_RST (0x0000); software must load it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
         s_q.st <= dagen_pkg::S_IDLE;
         s_q.sp <= dagen_pkg::SP_RST;
         s_q.lim <= dagen_pkg::LIMIT_RST;
         s_q.ctl <= dagen_pkg::REG_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // All outputs straight from the state record
   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign ag_ready = s_q.rdy;
   assign x_req = s_q.xreq;
   assign x_we = s_q.xwe;
   assign x_be = s_q.xbe;
   assign x_addr = s_q.xaddr;
   assign x_wdata = s_q.xwdata;
   assign y_req = s_q.yreq;
   assign y_addr = s_q.yaddr;
   assign p_req = s_q.preq;
   assign p_we = s_q.pwe;
   assign p_addr = s_q.paddr;
   assign p_wdata = s_q.pwdata;
   assign wb_valid = s_q.wbv;
   assign wb_reg = s_q.wbr;
   assign wb_value = s_q.wbval;
   assign ywb_valid = s_q.ywbv;
   assign ywb_reg = s_q.ywbr;
   assign ywb_value = s_q.ywbval;
   assign rsp_valid = s_q.rspv;
   assign rsp_data = s_q.rsp;
   assign rsp_ydata = s_q.rspy;
   assign stack_trap = s_q.trap;
   assign prot_violation = s_q.viol;
   assign stack_pointer_register = s_q.sp;
endmodule : data_address_generation_stack_check
`default_nettype wire

// file: testbench/dagen_asserts.sv
// Port-level assertions for the data address generator
`timescale 1ns/1ps
`default_nettype none
module dagen_asserts (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ag_valid,
   input wire logic ag_ready,
   input wire logic [2:0] ag_op,
   input wire logic [2:0] ag_mode,
   input wire logic [15:0] ag_lit,
   input wire logic ag_we,
   input wire logic ag_dual,
   input wire logic [7:0] status_low_byte,
   input wire logic x_req,
   input wire logic x_we,
   input wire logic [15:0] x_addr,
   input wire logic [15:0] x_wdata,
   input wire logic p_req,
   input wire logic rsp_valid,
   input wire logic stack_trap,
   input wire logic [15:0] stack_pointer_register
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Taken request
   wire logic tk = ag_valid && ag_ready;
   a_push_post_inc: assert property (tk && ag_op == dagen_pkg::OP_PUSH |=> x_req && x_we &&
      x_addr == $past(stack_pointer_register) && stack_pointer_register == $past(stack_pointer_register) + 16'h0002)
      else $error("push address or pointer step wrong");
   a_pop_pre_dec: assert property (tk && ag_op == dagen_pkg::OP_POP |=> x_req && !x_we &&
      x_addr == $past(stack_pointer_register) - 16'h0002) else $error("pop address wrong");
   a_trap_same_cycle: assert property (stack_trap |-> x_req) else $error("trap without address");
   a_low_trap: assert property (tk && ag_op == dagen_pkg::OP_PUSH &&
      stack_pointer_register < dagen_pkg::SFR_TOP |=> stack_trap) else $error("low stack not trapped");
   a_call_zero: assert property (tk && ag_op == dagen_pkg::OP_CALL |=> x_req ##1
      (x_req && x_wdata[15:8] == 8'h00)) else $error("call top byte not clear");
   a_exc_status: assert property (tk && ag_op == dagen_pkg::OP_EXC |=> x_req ##1
      (x_req && x_wdata[15:8] == $past(status_low_byte, 2))) else $error("status byte not pushed");
   a_win_extra: assert property (tk && ag_op == dagen_pkg::OP_MEM && !ag_we && !ag_dual &&
      ag_mode == dagen_pkg::AM_DIR16 && ag_lit[15] |=> p_req [*2] ##2 rsp_valid) else $error("window timing");
   a_near_direct: assert property (tk && ag_op == dagen_pkg::OP_MEM && ag_mode == dagen_pkg::AM_DIR13 |=>
      x_req && x_addr == ($past(ag_lit) & 16'h1fff)) else $error("near address wrong");
endmodule : dagen_asserts
bind data_address_generation_stack_check dagen_asserts dagen_asserts_i (.*);
`default_nettype wire

// file: testbench/data_address_generation_stack_check_test.sv
// Self-checking bench for the data address generator
`timescale 1ns/1ps
`default_nettype none
module data_address_generation_stack_check_test;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ag_valid = 0, ag_we = 0, ag_byte = 0, ag_dual = 0;
   logic pready, pslverr, ag_ready, x_req, x_we, y_req, p_req, p_we, wb_valid, ywb_valid, rsp_valid;
   logic stack_trap, prot_violation;
   logic [2:0] ag_op = 0, ag_mode = 0;
   logic [3:0] ag_reg = 0, ag_yreg = 0, wb_reg, ywb_reg;
   logic [1:0] ag_code = 0, x_be;
   logic [7:0] status_low_byte = 0, ag_tblpage = 0, pg;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata;
   logic [15:0] ag_ptr = 0, ag_mod = 0, ag_lit = 0, ag_old = 0, ag_yptr = 0, ag_ymod = 0, x_addr, x_wdata, x_rdata;
   logic [15:0] y_addr, y_rdata, wb_value, ywb_value, rsp_ydata, stack_pointer_register, d, pv;
   logic [22:0] ag_pc = 0, p_addr;
   logic [23:0] ag_wdata = 0, p_wdata, p_rdata, rsp_data;
   logic [31:0] rq[$], aq[$], wq[$];
   int fail_count = 0, n_tests = 0;
   data_address_generation_stack_check data_address_generation_stack_check_i (.*);
   data_memory_model data_memory_model_i (.*);
   always #2 pclk = ~pclk;
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : summarize
   // Bounded wait: pready or ag_ready
   task automatic hold(input bit sel);
      int n;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while ((sel ? pready : ag_ready) !== 1'b1 && n < 64);
      if ((sel ? pready : ag_ready) !== 1'b1) begin
         fail_count++;
         summarize();
      end
   endtask : hold
   // APB transfer; for a read, dv is the expected data
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dv);
      @(posedge pclk);
      if (!wr) aq.push_back(dv);
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= dv;
      @(posedge pclk);
      penable <= 1;
      hold(1);
      psel <= 0;
      penable <= 0;
   endtask : apb
   // Execution request; e is read expectation
   task automatic ag(input logic [2:0] op, md, input logic [3:0] r, input logic [15:0] p, m, l,
                     input logic w, input logic [23:0] e);
      @(posedge pclk);
      if (op == dagen_pkg::OP_POP || op == dagen_pkg::OP_TBLRD || (op == dagen_pkg::OP_MEM && !w)) rq.push_back(e);
      ag_valid <= 1;
      ag_op <= op;
      ag_mode <= md;
      ag_reg <= r;
      ag_ptr <= p;
      ag_mod <= m;
      ag_lit <= l;
      ag_we <= w;
      ag_wdata <= e;
      hold(0);
      ag_valid <= 0;
   endtask : ag
   // Outputs against queued notes
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite) chk("prdata", prdata, aq.size() ? aq.pop_front() : 'x);
      if (rsp_valid) chk("rsp_data", {8'h00, rsp_data}, rq.size() ? rq.pop_front() : 'x);
      if (wb_valid && wb_reg != 4'hf) chk("wb_value", {16'h0, wb_value}, wq.size() ? wq.pop_front() : 'x);
   end
   initial begin
      void'($urandom(32'h14f4));
      d = $urandom;
      pg = $urandom;
      ag_old = $urandom;
      ag_pc = $urandom;
      status_low_byte = $urandom;
      ag_yreg = $urandom;
      ag_yptr = $urandom;
      ag_ymod = $urandom;
      repeat (16) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      apb(0, dagen_pkg::OFS_SP, 32'h0800);
      apb(1, dagen_pkg::OFS_LIMIT, 32'h0901);
      apb(0, dagen_pkg::OFS_LIMIT, 32'h0900);
      apb(0, 12'hffc, 32'h0);
      // Push up to the limit and past it
      apb(1, dagen_pkg::OFS_SP, 32'h08fe);
      for (int i = 0; i < 3; i++) begin
         ag(dagen_pkg::OP_PUSH, 0, 4'hf, 0, 0, 0, 1, {8'h0, d + 16'(i)});
         apb(0, dagen_pkg::OFS_STATUS, {31'h0, i == 2});
      end
      apb(1, dagen_pkg::OFS_STATUS, 32'h7);
      for (int i = 2; i >= 0; i--) ag(dagen_pkg::OP_POP, 0, 4'hf, 0, 0, 0, 0, {8'h0, d + 16'(i)});
      apb(1, dagen_pkg::OFS_SP, 32'h07fe);
      ag(dagen_pkg::OP_PUSH, 0, 4'hf, 0, 0, 0, 1, {8'h0, d});
      ag(dagen_pkg::OP_POP, 0, 4'hf, 0, 0, 0, 0, {8'h0, d});
      apb(0, dagen_pkg::OFS_STATUS, 32'h2);
      // Call then exception, popped word by word
      apb(1, dagen_pkg::OFS_SP, 32'h0a00);
      for (int k = 0; k < 2; k++) begin
         ag(k ? dagen_pkg::OP_EXC : dagen_pkg::OP_CALL, 0, 4'hf, 0, 0, 0, 1, 0);
         ag(dagen_pkg::OP_POP, 0, 4'hf, 0, 0, 0, 0, {8'h0, k ? status_low_byte : 8'h00, 1'b0, ag_pc[22:16]});
         ag(dagen_pkg::OP_POP, 0, 4'hf, 0, 0, 0, 0, {8'h0, ag_pc[15:0]});
      end
      ag(dagen_pkg::OP_MEM, dagen_pkg::AM_DIR16, 0, 0, 0, 16'h1234, 1, {8'h0, d});
      ag(dagen_pkg::OP_MEM, dagen_pkg::AM_DIR16, 0, 0, 0, 16'h1234, 0, {8'h0, d});
      ag(dagen_pkg::OP_MEM, dagen_pkg::AM_DIR13, 0, 0, 0, 16'hf234, 0, {8'h0, d});
      ag_byte <= 1;
      ag(dagen_pkg::OP_MEM, dagen_pkg::AM_DIR16, 0, 0, 0, 16'h1235, 0, {8'h0, ag_old[15:8], d[15:8]});
      ag_byte <= 0;
      // Program window and table read
      apb(1, dagen_pkg::OFS_PAGE, {24'h0, pg});
      ag(dagen_pkg::OP_MEM, dagen_pkg::AM_DIR16, 0, 0, 0, 16'h8246, 0, {8'h0, {pg[0], 15'h0246} ^ 16'ha5a5});
      ag_tblpage <= pg;
      ag(dagen_pkg::OP_TBLRD, 0, 4'h2, 16'h4321, 0, 0, 0, {1'b1, pg[6:0], 16'h4321} ^ 24'h25a5a5);
      // Circular 0x1000..0x100f on pointer 3, past both bounds
      apb(1, dagen_pkg::OFS_MODCTL, 32'h0031);
      apb(1, dagen_pkg::OFS_XSTART, 32'h1000);
      apb(1, dagen_pkg::OFS_XEND, 32'h100f);
      wq.push_back(32'h1002);
      ag(dagen_pkg::OP_MEM, dagen_pkg::AM_POST, 3, 16'h100e, 16'h0004, 0, 0, {8'h0, 16'h100e ^ 16'h9c9c});
      ag(dagen_pkg::OP_MEM, dagen_pkg::AM_OFS, 3, 16'h100e, 16'h0004, 0, 0, {8'h0, 16'h1002 ^ 16'h9c9c});
      wq.push_back(32'h100e);
      ag(dagen_pkg::OP_MEM, dagen_pkg::AM_PRE, 3, 16'h1002, 16'hfffc, 0, 0, {8'h0, 16'h100e ^ 16'h9c9c});
      // Protected segments: general code refused, own code served
      apb(1, dagen_pkg::OFS_PROT, 32'h3);
      apb(1, dagen_pkg::OFS_STATUS, 32'h7);
      for (int k = 0; k < 4; k++) begin
         pv = k[1] ? dagen_pkg::SEC_LO : dagen_pkg::BOOT_LO;
         ag_code <= k[0] ? (k[1] ? dagen_pkg::CODE_SEC : dagen_pkg::CODE_BOOT) : dagen_pkg::CODE_GEN;
         ag(dagen_pkg::OP_MEM, dagen_pkg::AM_DIR16, 0, 0, 0, pv, 0, k[0] ? {8'h0, pv ^ 16'h9c9c} : 24'h0);
      end
      apb(0, dagen_pkg::OFS_STATUS, 32'h4);
      repeat (8) @(posedge pclk);
      summarize();
   end
endmodule : data_address_generation_stack_check_test
`default_nettype wire

// file: testbench/data_memory_model.sv
// Behavioural X, Y and program memories
`timescale 1ns/1ps
`default_nettype none
module data_memory_model (
   input wire logic pclk,
   input wire logic x_req,
   input wire logic x_we,
   input wire logic [1:0] x_be,
   input wire logic [15:0] x_addr,
   input wire logic [15:0] x_wdata,
   output logic [15:0] x_rdata,
   input wire logic y_req,
   input wire logic [15:0] y_addr,
   output logic [15:0] y_rdata,
   input wire logic p_req,
   input wire logic [22:0] p_addr,
   output logic [23:0] p_rdata
);
   logic [15:0] mem [logic [15:0]];
   logic [15:0] o;
   logic [15:0] a;
   initial begin
      x_rdata = 16'h0000;
      y_rdata = 16'h0000;
      p_rdata = 24'h000000;
   end
   // Data valid one cycle after a request, inverted otherwise so stale data never matches
   always @(posedge pclk) begin
      a = {x_addr[15:1], 1'b0};
      o = mem.exists(a) ? mem[a] : a ^ 16'h9c9c;
      x_rdata <= (x_req && !x_we) ? o : ~x_rdata;
      if (x_req && x_we)
         mem[a] = {x_be[1] ? x_wdata[15:8] : o[15:8], x_be[0] ? x_wdata[7:0] : o[7:0]};
      y_rdata <= y_req ? y_addr ^ 16'h9c9c : ~y_rdata;
      p_rdata <= p_req ? {1'b1, p_addr} ^ 24'h25a5a5 : ~p_rdata;
   end
endmodule : data_memory_model
`default_nettype wire
